//--- src/orw_pkg.sv
package orw_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ADDR_SETUP_A      = 16'h001E;
  localparam logic [15:0] ADDR_SETUP_B      = 16'h001F;
  localparam logic [15:0] ADDR_SERVICE      = 16'hFFFF;
  localparam logic [15:0] ADDR_CAUSE        = 16'h0030;

  // ---------------------------------------------------------------------------
  // Field positions, setup A
  // ---------------------------------------------------------------------------
  localparam int          A_PULLUP_DIS      = 7;
  localparam int          A_IRQ_FUNC        = 6;
  localparam int          A_OSC_HI          = 4;
  localparam int          A_OSC_LO          = 3;
  localparam int          A_RESET_PIN_EN    = 0;
  localparam logic [7:0]  A_RW_MASK         = 8'hD9;
  localparam logic [7:0]  A_POR_ONLY_MASK   = 8'h01;

  // ---------------------------------------------------------------------------
  // Field positions, setup B
  // ---------------------------------------------------------------------------
  localparam int          B_RATE_SEL        = 7;
  localparam int          B_MON_STOP_EN     = 6;
  localparam int          B_MON_RST_DIS     = 5;
  localparam int          B_MON_PWR_DIS     = 4;
  localparam int          B_TRIP_LEVEL      = 3;
  localparam int          B_SHORT_REC       = 2;
  localparam int          B_STOP_EN         = 1;
  localparam int          B_WDOG_DIS        = 0;
  localparam logic [7:0]  B_FREE_MASK       = 8'h28;
  localparam logic [7:0]  B_POR_ONLY_MASK   = 8'h08;

  // ---------------------------------------------------------------------------
  // Reset values and cause flags
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SETUP_RESET       = 8'h00;
  localparam int          CAUSE_WDOG        = 5;
  localparam int          CAUSE_MON         = 1;
  localparam int          CAUSE_POR         = 7;

  // ---------------------------------------------------------------------------
  // Oscillator selection
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_EXTERNAL = 2'b01,
    OSC_EXT_RC   = 2'b10,
    OSC_EXT_XTAL = 2'b11
  } orw_osc_t;

  // ---------------------------------------------------------------------------
  // Timing, in fast-clock cycles, except wakeup periods, which count wake-oscillator ticks
  // ---------------------------------------------------------------------------
  localparam int          WDOG_LONG_CYC     = 262128;
  localparam int          WDOG_SHORT_CYC    = 8176;
  localparam int          WAKE_LONG_CYC     = 16384;
  localparam int          WAKE_SHORT_CYC    = 512;
  localparam int          REC_SHORT_CYC     = 32;
  localparam int          REC_LONG_CYC      = 4096;
  localparam int          PIN_LOW_CYC       = 32;
  localparam int          PRE_W             = 12;
  localparam int          WD_W              = 6;
  localparam logic [11:0] PRE_SERVICE_MASK  = 12'h00F;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STOP    = 2'b01,
    ST_RECOVER = 2'b10
  } orw_state_t;

endpackage : orw_pkg

//--- src/orw_option_wdog.sv
// What this block does
// - Each option register accepts only its first write after any reset.
// - Trip-level and monitor reset-disable bits may be rewritten any time.
// - Option registers sit at 0x1E and 0x1F and read back at any time.
// - Reset clears option bits; reset-pin enable and trip level clear only on power-on.
// - Oscillator field decodes 00 internal, 01 external, 10 RC, 11 crystal.
// - Irq pin function active when set; pull-up removed when disable bit set.
// - Watchdog timeout 8176 cycles with rate bit set, 262128 when clear.
// - In stop, rate bit selects wakeup period of 512 or 16384 wake-oscillator ticks.
// - Monitor runs in stop only when stop-enable set and power-disable clear.
// - Monitor resets are blocked while reset-disable bit is set.
// - Monitor unpowered while power-disable bit is set.
// - Trip-level bit selects warning threshold when set, reset threshold when clear.
// - Stop recovery lasts 32 cycles with short-recovery set, else 4096.
// - Stop exit through a monitor reset always uses the long recovery.
// - Stop instruction runs only with stop-enable set, otherwise is illegal.
// - Watchdog inactive while its disable bit is set.
// - Watchdog is a 6-bit counter fed by a 12-bit prescaler overflow.
// - Watchdog overflow raises a reset after the selected timeout.
// - Any write to the service address clears watchdog and prescaler stages 12..5.
// - Watchdog reset drives reset pin low 32 cycles when pin enable set.
// - Watchdog reset sets the watchdog cause flag in the reset cause register.
// - Reading the service address returns the reset vector low byte.
// - Internal reset clears both prescaler and watchdog counter.
// - Stop removes the watchdog clock; stop entry clears the prescaler only while the watchdog is disabled, the watchdog counter keeps its count.
//
// The register addresses and the plain strobed port were decided locally.
module orw_option_wdog #(
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        stop_request,
  input  wire logic        wake_event,
  input  wire logic        mon_trip,
  input  wire logic        wake_osc_tick,
  output logic             stop_granted,
  output logic             illegal_opcode,
  output logic             in_stop,
  output logic             recovery_done,
  output logic             wdog_reset,
  output logic             reset_pin_low,
  output logic             mon_reset,
  output logic             mon_powered,
  output logic             mon_warn_level,
  output logic             irq_pin_function,
  output logic             irq_pullup_on,
  output logic      [1:0]  osc_select,
  output logic             wakeup_short,
  output logic             wakeup_pulse
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           setup_a;
    logic [7:0]           setup_b;
    logic                 lock_a;
    logic                 lock_b;
    logic [7:0]           cause;
    logic [11:0]          pre;
    logic [5:0]           wd;
    orw_pkg::orw_state_t  st;
    logic [11:0]          rec_cnt;
    logic                 rec_long;
    logic [5:0]           pin_cnt;
    logic [13:0]          wake_cnt;
    logic                 trip_m;
    logic                 trip_s;
    logic                 wtick_m;
    logic                 wtick_s;
    logic                 wtick_d;
    logic [7:0]           rdata;
    logic                 stop_granted;
    logic                 illegal;
    logic                 wdog_rst;
    logic                 mon_rst;
    logic                 rec_done;
    logic                 wake_pulse;
  } orw_regs_t;

  orw_regs_t s_reg;
  orw_regs_t s_next;

  // Only retained bits survive a non-power-on reset.
  function automatic logic [7:0] keep_bits(input logic [7:0] v, input logic [7:0] m);
    keep_bits = v & m;
  endfunction : keep_bits

  logic wr_a;
  logic wr_b;
  logic wr_svc;
  logic pre_ovf;
  logic wd_ovf;
  logic wtick_rise;
  logic wake_hit;

  always_comb
  begin
    s_next      = s_reg;
    wr_a        = bus_wr && (bus_addr == orw_pkg::ADDR_SETUP_A);
    wr_b        = bus_wr && (bus_addr == orw_pkg::ADDR_SETUP_B);
    wr_svc      = bus_wr && (bus_addr == orw_pkg::ADDR_SERVICE);
    wtick_rise  = s_reg.wtick_s && !s_reg.wtick_d;
    pre_ovf     = 1'b0;
    wd_ovf      = 1'b0;
    wake_hit    = 1'b0;

    s_next.trip_m  = mon_trip;
    s_next.trip_s  = s_reg.trip_m;
    s_next.wtick_m = wake_osc_tick;
    s_next.wtick_s = s_reg.wtick_m;
    s_next.wtick_d = s_reg.wtick_s;

    s_next.stop_granted = 1'b0;
    s_next.illegal      = 1'b0;
    s_next.wdog_rst     = 1'b0;
    s_next.rec_done     = 1'b0;
    s_next.wake_pulse   = 1'b0;

    // -------------------------------------------------------------------------
    // Option register writes
    // -------------------------------------------------------------------------
    if (wr_a && !s_reg.lock_a)
    begin
      s_next.setup_a = bus_wdata & orw_pkg::A_RW_MASK;
      s_next.lock_a  = 1'b1;
    end
    if (wr_b)
    begin
      if (!s_reg.lock_b)
      begin
        s_next.setup_b = bus_wdata;
        s_next.lock_b  = 1'b1;
      end
      else
      begin
        s_next.setup_b = (s_reg.setup_b & ~orw_pkg::B_FREE_MASK)
                       | (bus_wdata & orw_pkg::B_FREE_MASK);
      end
    end

    // -------------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------------
    if (bus_rd)
    begin
      case (bus_addr)
        orw_pkg::ADDR_SETUP_A: s_next.rdata = s_reg.setup_a;
        orw_pkg::ADDR_SETUP_B: s_next.rdata = s_reg.setup_b;
        orw_pkg::ADDR_SERVICE: s_next.rdata = RESET_VECTOR_LO;
        orw_pkg::ADDR_CAUSE:   s_next.rdata = s_reg.cause;
        default:               s_next.rdata = 8'h00;
      endcase
    end
    else
    begin
      s_next.rdata = 8'h00;
    end

    // -------------------------------------------------------------------------
    // Stop, recovery and wakeup sequencing
    // -------------------------------------------------------------------------
    case (s_reg.st)
      orw_pkg::ST_RUN:
      begin
        if (stop_request)
        begin
          if (s_reg.setup_b[orw_pkg::B_STOP_EN])
          begin
            s_next.st           = orw_pkg::ST_STOP;
            s_next.stop_granted = 1'b1;
            s_next.pre          = 12'h000;
            s_next.wake_cnt     = 14'h0000;
          end
          else
          begin
            s_next.illegal = 1'b1;
          end
        end
      end
      orw_pkg::ST_STOP:
      begin
        if (wtick_rise)
        begin
          s_next.wake_cnt = s_reg.wake_cnt + 14'h0001;
          if (s_reg.setup_b[orw_pkg::B_RATE_SEL])
            wake_hit = (s_reg.wake_cnt == 14'(orw_pkg::WAKE_SHORT_CYC - 1));
          else
            wake_hit = (s_reg.wake_cnt == 14'(orw_pkg::WAKE_LONG_CYC - 1));
          if (wake_hit)
          begin
            s_next.wake_cnt   = 14'h0000;
            s_next.wake_pulse = 1'b1;
          end
        end
        if (wake_event || wake_hit)
        begin
          s_next.st       = orw_pkg::ST_RECOVER;
          s_next.rec_cnt  = 12'h000;
          s_next.rec_long = !s_reg.setup_b[orw_pkg::B_SHORT_REC];
        end
      end
      orw_pkg::ST_RECOVER:
      begin
        s_next.rec_cnt = s_reg.rec_cnt + 12'h001;
        if ((s_reg.rec_long && s_reg.rec_cnt == 12'(orw_pkg::REC_LONG_CYC - 1)) ||
            (!s_reg.rec_long && s_reg.rec_cnt == 12'(orw_pkg::REC_SHORT_CYC - 1)))
        begin
          s_next.st       = orw_pkg::ST_RUN;
          s_next.rec_done = 1'b1;
        end
      end
      default: s_next.st = orw_pkg::ST_RUN;
    endcase

    // -------------------------------------------------------------------------
    // Watchdog: prescaler and counter run only outside stop
    // -------------------------------------------------------------------------
    if (s_reg.st != orw_pkg::ST_STOP && !s_reg.setup_b[orw_pkg::B_WDOG_DIS])
    begin
      s_next.pre = s_reg.pre + 12'h001;
      pre_ovf    = (s_reg.pre == 12'hFFF);
      if (pre_ovf)
        s_next.wd = s_reg.wd + 6'h01;
      if (s_reg.setup_b[orw_pkg::B_RATE_SEL])
        wd_ovf = (s_reg.wd == 6'h01) && (s_reg.pre == 12'(orw_pkg::WDOG_SHORT_CYC - 4096 - 1));
      else
        wd_ovf = pre_ovf && (s_reg.wd == 6'h3F) ||
                 (s_reg.wd == 6'h3F && s_reg.pre == 12'(orw_pkg::WDOG_LONG_CYC - 258048 - 1));
    end
    if (wr_svc)
    begin
      s_next.wd  = 6'h00;
      s_next.pre = s_reg.pre & orw_pkg::PRE_SERVICE_MASK;
    end
    if (wd_ovf && !wr_svc)
    begin
      s_next.wdog_rst = 1'b1;
      s_next.wd       = 6'h00;
      s_next.pre      = 12'h000;
      s_next.cause[orw_pkg::CAUSE_WDOG] = 1'b1;
      // The internal-reset cycle holds the count without a step, so one is taken off here.
      if (s_reg.setup_a[orw_pkg::A_RESET_PIN_EN])
        s_next.pin_cnt = 6'(orw_pkg::PIN_LOW_CYC - 1);
    end
    else if (s_reg.pin_cnt != 6'h00)
    begin
      s_next.pin_cnt = s_reg.pin_cnt - 6'h01;
    end

    // -------------------------------------------------------------------------
    // Supply monitor
    // -------------------------------------------------------------------------
    s_next.mon_rst = s_reg.trip_s && !s_reg.setup_b[orw_pkg::B_MON_RST_DIS]
                   && mon_powered_f(s_reg.setup_b, s_reg.st);
    if (s_next.mon_rst)
    begin
      s_next.cause[orw_pkg::CAUSE_MON] = 1'b1;
      if (s_reg.st == orw_pkg::ST_STOP)
      begin
        s_next.st       = orw_pkg::ST_RECOVER;
        s_next.rec_cnt  = 12'h000;
        s_next.rec_long = 1'b1;
      end
    end
  end

  // Monitor power follows its disable bit, and in stop also its stop enable.
  function automatic logic mon_powered_f(input logic [7:0] b, input orw_pkg::orw_state_t st);
    mon_powered_f = !b[orw_pkg::B_MON_PWR_DIS] &&
                    ((st != orw_pkg::ST_STOP) || b[orw_pkg::B_MON_STOP_EN]);
  endfunction : mon_powered_f

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else if (por)
    begin
      s_reg       <= '0;
      s_reg.cause <= 8'h80;
    end
    else if (s_reg.wdog_rst)
    begin
      // Internal reset: clears options except the power-on-only bits.
      s_reg          <= '0;
      s_reg.setup_a  <= keep_bits(s_reg.setup_a, orw_pkg::A_POR_ONLY_MASK);
      s_reg.setup_b  <= keep_bits(s_reg.setup_b, orw_pkg::B_POR_ONLY_MASK);
      s_reg.cause    <= s_reg.cause;
      s_reg.pin_cnt  <= s_reg.pin_cnt;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign bus_rdata        = s_reg.rdata;
  assign stop_granted     = s_reg.stop_granted;
  assign illegal_opcode   = s_reg.illegal;
  assign in_stop          = (s_reg.st == orw_pkg::ST_STOP);
  assign recovery_done    = s_reg.rec_done;
  assign wdog_reset       = s_reg.wdog_rst;
  assign reset_pin_low    = (s_reg.pin_cnt != 6'h00);
  assign mon_reset        = s_reg.mon_rst;
  assign mon_powered      = mon_powered_f(s_reg.setup_b, s_reg.st);
  assign mon_warn_level   = s_reg.setup_b[orw_pkg::B_TRIP_LEVEL];
  assign irq_pin_function = s_reg.setup_a[orw_pkg::A_IRQ_FUNC];
  assign irq_pullup_on    = !s_reg.setup_a[orw_pkg::A_PULLUP_DIS];
  assign osc_select       = s_reg.setup_a[orw_pkg::A_OSC_HI:orw_pkg::A_OSC_LO];
  assign wakeup_short     = s_reg.setup_b[orw_pkg::B_RATE_SEL];
  assign wakeup_pulse     = s_reg.wake_pulse;

endmodule : orw_option_wdog

//--- tb/orw_option_wdog_props.sv
module orw_option_wdog_props #(
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        por,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        stop_request,
  input wire logic        wake_event,
  input wire logic        stop_granted,
  input wire logic        illegal_opcode,
  input wire logic        in_stop,
  input wire logic        recovery_done,
  input wire logic        wdog_reset,
  input wire logic        reset_pin_low,
  input wire logic        mon_reset,
  input wire logic        mon_powered,
  input wire logic [1:0]  osc_select
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [5:0]  pin_run_reg;
  logic [19:0] wd_age_reg;
  logic [12:0] rec_age_reg;
  logic        wd_clear;

  // Stop only freezes the age: the watchdog keeps its count across stop,
  // so clearing here would make the bound too strict.
  assign wd_clear = por | wdog_reset | (bus_wr & (bus_addr == orw_pkg::ADDR_SERVICE));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_run_reg <= 6'h00;
      wd_age_reg  <= 20'h0_0000;
      rec_age_reg <= 13'h0000;
    end
    else
    begin
      pin_run_reg <= reset_pin_low ? pin_run_reg + 6'h01 : 6'h00;
      wd_age_reg  <= wd_clear ? 20'h0_0000 : wd_age_reg + {19'h0_0000, ~&wd_age_reg & ~in_stop};
      rec_age_reg <= in_stop ? 13'h0000 : rec_age_reg + {12'h000, ~&rec_age_reg};
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_stop_asked;
    stop_request && !in_stop;
  endsequence
  sequence s_stop_answered;
    ##[1:2] (stop_granted || illegal_opcode);
  endsequence

  property p_stop_answer;
    s_stop_asked |-> s_stop_answered;
  endproperty
  property p_grant_stop;
    stop_granted |-> ##[0:1] in_stop;
  endproperty
  property p_rd_idle;
    !$past(bus_rd) |-> bus_rdata == 8'h00;
  endproperty
  property p_svc_read;
    bus_rd && bus_addr == orw_pkg::ADDR_SERVICE |=> bus_rdata == RESET_VECTOR_LO;
  endproperty
  property p_pin_len;
    $fell(reset_pin_low) |-> pin_run_reg == 6'h20;
  endproperty
  property p_opt_hold;
    !$past(bus_wr) && !$past(por) && !$past(wdog_reset) && !$past(wdog_reset, 2)
      |-> $stable(osc_select);
  endproperty
  property p_mon_pwr;
    mon_reset |-> mon_powered;
  endproperty
  property p_rec_time;
    recovery_done |-> rec_age_reg >= 13'h001C && rec_age_reg <= 13'h1004;
  endproperty
  property p_wd_gap;
    wdog_reset |-> wd_age_reg >= 20'h0_1FD6;
  endproperty

  a_stop_answer: assert property (p_stop_answer)
    else $error("stop request not answered");
  a_grant_stop: assert property (p_grant_stop)
    else $error("grant without stop state");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_svc_read: assert property (p_svc_read)
    else $error("service read not vector byte");
  a_pin_len: assert property (p_pin_len)
    else $error("reset pin low length wrong");
  a_opt_hold: assert property (p_opt_hold)
    else $error("oscillator select changed without write");
  a_mon_pwr: assert property (p_mon_pwr)
    else $error("monitor reset while unpowered");
  a_rec_time: assert property (p_rec_time)
    else $error("recovery time out of range");
  a_wd_gap: assert property (p_wd_gap)
    else $error("watchdog fired early");
endmodule : orw_option_wdog_props

bind orw_option_wdog orw_option_wdog_props #(.RESET_VECTOR_LO(RESET_VECTOR_LO)) u_props (
  .sys_clk(sys_clk), .rst(rst), .por(por), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_request(stop_request),
  .wake_event(wake_event), .stop_granted(stop_granted), .illegal_opcode(illegal_opcode),
  .in_stop(in_stop), .recovery_done(recovery_done), .wdog_reset(wdog_reset),
  .reset_pin_low(reset_pin_low), .mon_reset(mon_reset), .mon_powered(mon_powered),
  .osc_select(osc_select)
);

//--- tb/orw_option_wdog_test.sv
module orw_option_wdog_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rst, por, bus_wr, bus_rd;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, d;
  logic        stop_request, wake_event, mon_trip, wake_osc_tick;
  logic        stop_granted, illegal_opcode, in_stop, recovery_done;
  logic        wdog_reset, reset_pin_low, mon_reset, mon_powered;
  logic        mon_warn_level, irq_pin_function, irq_pullup_on;
  logic        wakeup_short, wakeup_pulse;
  logic [1:0]  osc_select;
  logic [31:0] r;
  int          miscompares, samples_checked, n, c;
  int          model_a, model_b, lock_a, lock_b;

  orw_option_wdog dut (
    .sys_clk(sys_clk), .rst(rst), .por(por), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .stop_request(stop_request), .wake_event(wake_event), .mon_trip(mon_trip),
    .wake_osc_tick(wake_osc_tick), .stop_granted(stop_granted),
    .illegal_opcode(illegal_opcode), .in_stop(in_stop), .recovery_done(recovery_done),
    .wdog_reset(wdog_reset), .reset_pin_low(reset_pin_low), .mon_reset(mon_reset),
    .mon_powered(mon_powered), .mon_warn_level(mon_warn_level),
    .irq_pin_function(irq_pin_function), .irq_pullup_on(irq_pullup_on),
    .osc_select(osc_select), .wakeup_short(wakeup_short), .wakeup_pulse(wakeup_pulse)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    wake_osc_tick <= wake_osc_tick ^ ($urandom_range(3) == 0);

  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic sig(input int k);
    case (k)
      0: return stop_granted;
      1: return illegal_opcode;
      2: return recovery_done;
      3: return wdog_reset;
      4: return mon_reset;
      default: return reset_pin_low;
    endcase
  endfunction : sig

  // Polls from just after the current edge, so a one-cycle answer is not missed.
  task automatic wait_for(input int k, input int limit, output int cnt);
    cnt = 0;
    #1;
    while (sig(k) !== 1'b1 && cnt < limit)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (sig(k) !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
  endtask : wait_for

  task automatic count_pulses(input int k, input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles)
    begin
      @(posedge sys_clk);
      #1;
      cnt += (sig(k) === 1'b1);
    end
  endtask : count_pulses

  task automatic bus_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    bus_addr  <= addr;
    bus_wdata <= data;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
    if (addr == orw_pkg::ADDR_SETUP_A && lock_a == 0)
      model_a = data & orw_pkg::A_RW_MASK;
    if (addr == orw_pkg::ADDR_SETUP_B)
      model_b = lock_b ? ((model_b & 8'hD7) | (data & orw_pkg::B_FREE_MASK)) : data;
    lock_a |= (addr == orw_pkg::ADDR_SETUP_A);
    lock_b |= (addr == orw_pkg::ADDR_SETUP_B);
  endtask : bus_write

  task automatic bus_read(input logic [15:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    bus_addr <= addr;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    #1;
    data = bus_rdata;
  endtask : bus_read

  task automatic check_regs;
    bus_read(orw_pkg::ADDR_SETUP_A, d);
    check("setup_a", d, model_a[7:0]);
    bus_read(orw_pkg::ADDR_SETUP_B, d);
    check("setup_b", d, model_b[7:0]);
    check("osc_select", osc_select, model_a[4:3]);
    check("irq_pin_function", irq_pin_function, model_a[6]);
    check("irq_pullup_on", irq_pullup_on, !model_a[7]);
    check("mon_warn_level", mon_warn_level, model_b[3]);
    check("mon_powered", mon_powered, !model_b[4]);
    check("wakeup_short", wakeup_short, model_b[7]);
  endtask : check_regs

  task automatic pulse_por;
    @(posedge sys_clk);
    por <= 1'b1;
    @(posedge sys_clk);
    por <= 1'b0;
    model_a = 0;
    model_b = 0;
    lock_a  = 0;
    lock_b  = 0;
  endtask : pulse_por

  task automatic strobe(input int k);
    @(posedge sys_clk);
    stop_request <= (k == 0);
    wake_event   <= (k == 1);
    @(posedge sys_clk);
    stop_request <= 1'b0;
    wake_event   <= 1'b0;
  endtask : strobe

  task automatic mon_probe(input int expect_reset);
    int c1;
    int c2;
    @(posedge sys_clk);
    mon_trip <= 1'b1;
    count_pulses(4, 6, c1);
    mon_trip <= 1'b0;
    count_pulses(4, 8, c2);
    check("mon_reset", (c1 + c2) > 0, expect_reset);
  endtask : mon_probe

  initial
  begin
    {rst, por, bus_wr, bus_rd, stop_request, wake_event, mon_trip} = 7'h40;
    bus_addr      = 16'h0000;
    bus_wdata     = 8'h00;
    wake_osc_tick = 1'b0;
    r = $urandom(32'h3fd6_fd7f);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    bus_read(orw_pkg::ADDR_CAUSE, d);
    check("cause", d, 8'h00);
    bus_read(orw_pkg::ADDR_SERVICE, d);
    check("vector", d, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      pulse_por();
      bus_write(orw_pkg::ADDR_SETUP_A, 8'(i << 3));
      check_regs();
    end
    pulse_por();
    r = $urandom();
    bus_write(orw_pkg::ADDR_SETUP_A, r[7:0] | 8'h01);
    bus_write(orw_pkg::ADDR_SETUP_A, ~r[7:0]);
    check_regs();
    bus_write(orw_pkg::ADDR_SETUP_B, 8'h86 | (r[15:8] & 8'h08));
    bus_write(orw_pkg::ADDR_SETUP_B, r[23:16] & 8'hC7);
    check_regs();
    mon_probe(1);
    bus_write(orw_pkg::ADDR_SETUP_B, 8'h28);
    check_regs();
    mon_probe(0);
    strobe(0);
    wait_for(0, 3, n);
    repeat (20) @(posedge sys_clk);
    strobe(1);
    wait_for(2, 4200, n);
    check("short recovery", n >= 30 && n <= 34, 1'b1);
    repeat (3)
    begin
      // Servicing right after stop keeps the full timeout in force.
      bus_write(orw_pkg::ADDR_SERVICE, 8'($urandom()));
      count_pulses(3, 6000, c);
      check("serviced watchdog", c, 0);
    end
    bus_write(orw_pkg::ADDR_SERVICE, 8'h00);
    wait_for(3, 8300, n);
    check("watchdog timeout", n >= 8150 && n <= 8180, 1'b1);
    wait_for(5, 4, n);
    c = 0;
    while (reset_pin_low === 1'b1 && c < 40)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    check("pin low cycles", c, 32);
    model_a &= 1;
    model_b &= 8;
    lock_a  = 0;
    lock_b  = 0;
    bus_read(orw_pkg::ADDR_CAUSE, d);
    check("watchdog cause", d[5], 1'b1);
    check_regs();
    strobe(0);
    wait_for(1, 3, n);
    bus_write(orw_pkg::ADDR_SETUP_B, 8'h01);
    count_pulses(3, 9000, c);
    check("disabled watchdog", c, 0);
    pulse_por();
    bus_read(orw_pkg::ADDR_CAUSE, d);
    check("power-on cause", d[7], 1'b1);
    check_regs();
    conclude();
  end
endmodule : orw_option_wdog_test
